// [verilog/dep_engine.sv]
// decimal edit pattern engine: runs the pattern operator stream of the
// packed-to-character edit. assumes a byte memory port whose ack is a
// one-cycle pulse answering a held request; addresses are byte addresses.
`timescale 1ns/100ps
`include "dep_consts.svh"
module dep_engine #(parameter int AW = 32, parameter int LW = 5)
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              start,
  input  wire logic [LW-1:0]     src_len,
  input  wire logic [AW-1:0]     src_addr,
  input  wire logic [AW-1:0]     pat_addr,
  input  wire logic [AW-1:0]     dst_addr,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [AW-1:0]          mem_addr,
  output logic [7:0]             mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [7:0]        mem_rdata,
  output logic                   busy,
  output logic                   done,
  output logic                   bad_op,
  output logic                   signif,
  output logic                   zero_flag,
  output logic                   negative,
  output logic [15:0]            fill_sign_holder,
  output logic [AW-1:0]          dst_next
);
  import dep_pkg::*;

  if (AW < 8 || LW < 1 || LW > 8)
  begin : bad_params
    $error("dep_engine: unsupported AW or LW");
  end

  dep_state_type state_ff;
  logic [AW-1:0] pat_ff;
  logic [AW-1:0] dst_ff;
  logic [7:0]    op_ff;
  logic [3:0]    cnt_ff;
  logic [15:0]   holder_ff;
  logic          signif_ff;
  logic          zero_ff;
  logic          neg_ff;
  logic          busy_ff;
  logic          done_ff;
  logic          bad_ff;
  logic          adv_ff;
  logic          pend_ff;
  logic [7:0]    pend_ch_ff;
  logic [AW-1:0] addr_ff;
  logic [7:0]    wdata_ff;
  logic          we_ff;
  logic [3:0]    digit;
  logic          dig_go;
  logic [7:0]    fill_ch;
  logic [7:0]    sign_ch;
  logic [7:0]    dig_ch;
  logic [AW-1:0] dst_after;

  dep_cursor_if #(.AW(AW), .LW(LW)) cur_if ();

  dep_digit_cursor #(.AW(AW), .LW(LW)) u_cursor
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .cur     (cur_if.cursor)
  );

  function automatic logic is_rep(input logic [7:0] op, input logic [3:0] g);
    is_rep = (op[7:4] == g) && (op[3:0] != 4'h0);
  endfunction

  function automatic logic needs_arg(input logic [7:0] op);
    needs_arg = (op[7:3] == 5'b01000) && (op[2:0] != 3'h5) &&
                (op[2:0] != 3'h7);
  endfunction

  assign fill_ch   = holder_ff[`DEP_FILL_MSB:`DEP_FILL_LSB];
  assign sign_ch   = holder_ff[`DEP_SIGN_MSB:`DEP_SIGN_LSB];
  // exhausted source reads as zero digits without a memory cycle
  assign digit     = cur_if.empty ? 4'h0 :
                     (cur_if.hi_nib ? mem_rdata[7:4] : mem_rdata[3:0]);
  assign dig_go    = (state_ff == ST_DIGIT) && (mem_ack || cur_if.empty);
  assign dig_ch    = (signif_ff || digit != 4'h0) ?
                     (`DEP_CHAR_ZERO | {4'h0, digit}) : fill_ch;
  assign dst_after = adv_ff ? dst_ff + 1'b1 : dst_ff;

  assign cur_if.load    = ce && (state_ff == ST_IDLE) && start;
  assign cur_if.advance = ce && dig_go;
  assign cur_if.base    = src_addr;
  assign cur_if.len     = src_len;

  assign mem_req = busy_ff && (state_ff != ST_IDLE) &&
                   !((state_ff == ST_DIGIT) && cur_if.empty);
  assign mem_we           = we_ff;
  assign mem_addr         = addr_ff;
  assign mem_wdata        = wdata_ff;
  assign busy             = busy_ff;
  assign done             = done_ff;
  assign bad_op           = bad_ff;
  assign signif           = signif_ff;
  assign zero_flag        = zero_ff;
  assign negative         = neg_ff;
  assign fill_sign_holder = holder_ff;
  assign dst_next         = dst_ff;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      state_ff   <= ST_IDLE;
      pat_ff     <= '0;
      dst_ff     <= '0;
      op_ff      <= 8'h00;
      cnt_ff     <= 4'h0;
      holder_ff  <= {`DEP_SIGN_POS, `DEP_FILL_RST};
      signif_ff  <= 1'b0;
      zero_ff    <= 1'b1;
      neg_ff     <= 1'b0;
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      bad_ff     <= 1'b0;
      adv_ff     <= 1'b0;
      pend_ff    <= 1'b0;
      pend_ch_ff <= 8'h00;
      addr_ff    <= '0;
      wdata_ff   <= 8'h00;
      we_ff      <= 1'b0;
    end
    else if (ce)
    begin
      done_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
          if (start)
          begin
            pat_ff   <= pat_addr;
            dst_ff   <= dst_addr;
            busy_ff  <= 1'b1;
            bad_ff   <= 1'b0;
            we_ff    <= 1'b0;
            // sign nibble sits in the low half of the last byte
            addr_ff  <= src_addr + AW'(src_len[LW-1:1]);
            state_ff <= ST_SIGN;
          end
        ST_SIGN:
          if (mem_ack)
          begin
            neg_ff    <= (mem_rdata[3:0] == `DEP_NEG_NIB_A) ||
                         (mem_rdata[3:0] == `DEP_NEG_NIB_B);
            holder_ff <= {((mem_rdata[3:0] == `DEP_NEG_NIB_A) ||
                           (mem_rdata[3:0] == `DEP_NEG_NIB_B)) ?
                          `DEP_SIGN_NEG : `DEP_SIGN_POS, `DEP_FILL_RST};
            signif_ff <= 1'b0;
            zero_ff   <= 1'b1;
            addr_ff   <= pat_ff;
            state_ff  <= ST_FETCH;
          end
        ST_FETCH:
          if (mem_ack)
          begin
            op_ff   <= mem_rdata;
            pat_ff  <= pat_ff + 1'b1;
            addr_ff <= pat_ff + 1'b1;
            cnt_ff  <= mem_rdata[3:0];
            adv_ff  <= 1'b1;
            if (mem_rdata == `DEP_OP_STOP)
            begin
              busy_ff  <= 1'b0;
              done_ff  <= 1'b1;
              state_ff <= ST_IDLE;
            end
            else if (mem_rdata == `DEP_OP_CLOSE_FLOAT)
            begin
              if (!signif_ff)
              begin
                signif_ff <= 1'b1;
                addr_ff   <= dst_ff;
                wdata_ff  <= sign_ch;
                we_ff     <= 1'b1;
                state_ff  <= ST_WRITE;
              end
            end
            else if (mem_rdata == `DEP_OP_DROP_SIG)
              signif_ff <= 1'b0;
            else if (mem_rdata == `DEP_OP_FORCE_SIG)
              signif_ff <= 1'b1;
            else if (mem_rdata == `DEP_OP_EMIT_SIGN)
            begin
              addr_ff  <= dst_ff;
              wdata_ff <= sign_ch;
              we_ff    <= 1'b1;
              state_ff <= ST_WRITE;
            end
            else if (needs_arg(mem_rdata))
              state_ff <= ST_ARG;
            else if (is_rep(mem_rdata, `DEP_GRP_FILL))
            begin
              cnt_ff   <= mem_rdata[3:0] - 4'h1;
              addr_ff  <= dst_ff;
              wdata_ff <= fill_ch;
              we_ff    <= 1'b1;
              state_ff <= ST_WRITE;
            end
            else if (is_rep(mem_rdata, `DEP_GRP_MOVE) ||
                     is_rep(mem_rdata, `DEP_GRP_FLOAT))
            begin
              addr_ff  <= cur_if.byte_addr;
              state_ff <= ST_DIGIT;
            end
            else
            begin
              // unknown operator: stop rather than guess at its length
              bad_ff   <= 1'b1;
              busy_ff  <= 1'b0;
              done_ff  <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        ST_ARG:
          if (mem_ack)
          begin
            pat_ff   <= pat_ff + 1'b1;
            addr_ff  <= pat_ff + 1'b1;
            state_ff <= ST_FETCH;
            unique case (op_ff)
              `DEP_OP_SET_FILL:
                holder_ff[`DEP_FILL_MSB:`DEP_FILL_LSB] <= mem_rdata;
              `DEP_OP_SET_SIGN:
                holder_ff[`DEP_SIGN_MSB:`DEP_SIGN_LSB] <= mem_rdata;
              `DEP_OP_SET_POS:
                if (!neg_ff)
                  holder_ff[`DEP_SIGN_MSB:`DEP_SIGN_LSB] <= mem_rdata;
              `DEP_OP_SET_NEG:
                if (neg_ff)
                  holder_ff[`DEP_SIGN_MSB:`DEP_SIGN_LSB] <= mem_rdata;
              `DEP_OP_LITERAL:
              begin
                addr_ff  <= dst_ff;
                wdata_ff <= signif_ff ? mem_rdata : fill_ch;
                we_ff    <= 1'b1;
                state_ff <= ST_WRITE;
              end
              default:
                if (zero_ff)
                begin
                  // length trusted nonzero and inside written output
                  addr_ff  <= dst_ff - AW'(mem_rdata);
                  wdata_ff <= fill_ch;
                  adv_ff   <= 1'b0;
                  we_ff    <= 1'b1;
                  state_ff <= ST_WRITE;
                end
            endcase
          end
        ST_DIGIT:
          if (dig_go)
          begin
            cnt_ff   <= cnt_ff - 4'h1;
            addr_ff  <= dst_ff;
            we_ff    <= 1'b1;
            state_ff <= ST_WRITE;
            if (digit != 4'h0)
            begin
              signif_ff <= 1'b1;
              zero_ff   <= 1'b0;
            end
            if (op_ff[7:4] == `DEP_GRP_FLOAT && digit != 4'h0 && !signif_ff)
            begin
              wdata_ff   <= sign_ch;
              pend_ff    <= 1'b1;
              pend_ch_ff <= dig_ch;
            end
            else
              wdata_ff <= dig_ch;
          end
        ST_WRITE:
          if (mem_ack)
          begin
            dst_ff <= dst_after;
            adv_ff <= 1'b1;
            if (pend_ff)
            begin
              pend_ff  <= 1'b0;
              addr_ff  <= dst_after;
              wdata_ff <= pend_ch_ff;
            end
            else if (op_ff[7:4] == `DEP_GRP_FILL && cnt_ff != 4'h0)
            begin
              cnt_ff  <= cnt_ff - 4'h1;
              addr_ff <= dst_after;
            end
            else if (op_ff[7:5] == 3'b101 - 3'b001 - 3'b000 &&
                     cnt_ff != 4'h0)
            begin
              we_ff    <= 1'b0;
              addr_ff  <= cur_if.byte_addr;
              state_ff <= ST_DIGIT;
            end
            else if ((op_ff[7:4] == `DEP_GRP_MOVE ||
                      op_ff[7:4] == `DEP_GRP_FLOAT) && cnt_ff != 4'h0)
            begin
              we_ff    <= 1'b0;
              addr_ff  <= cur_if.byte_addr;
              state_ff <= ST_DIGIT;
            end
            else
            begin
              we_ff    <= 1'b0;
              addr_ff  <= pat_ff;
              state_ff <= ST_FETCH;
            end
          end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
endmodule

// [verilog/dep_consts.svh]
// constants of the decimal edit pattern engine: opcodes, characters,
// holder field positions. assumes inclusion by bare name from design files.
`ifndef DEP_CONSTS_SVH
`define DEP_CONSTS_SVH
`define DEP_OP_STOP        8'h00
`define DEP_OP_CLOSE_FLOAT 8'h01
`define DEP_OP_DROP_SIG    8'h02
`define DEP_OP_FORCE_SIG   8'h03
`define DEP_OP_EMIT_SIGN   8'h04
`define DEP_OP_SET_FILL    8'h40
`define DEP_OP_SET_SIGN    8'h41
`define DEP_OP_SET_POS     8'h42
`define DEP_OP_SET_NEG     8'h43
`define DEP_OP_LITERAL     8'h44
`define DEP_OP_PATCH       8'h46
`define DEP_GRP_FILL       4'h8
`define DEP_GRP_MOVE       4'h9
`define DEP_GRP_FLOAT      4'ha
`define DEP_FILL_RST       8'h20
`define DEP_SIGN_POS       8'h20
`define DEP_SIGN_NEG       8'h2d
`define DEP_CHAR_ZERO      8'h30
`define DEP_NEG_NIB_A      4'hb
`define DEP_NEG_NIB_B      4'hd
`define DEP_FILL_LSB       0
`define DEP_FILL_MSB       7
`define DEP_SIGN_LSB       8
`define DEP_SIGN_MSB       15
`endif

// [verilog/dep_pkg.sv]
// types of the decimal edit pattern engine.
// assumes nothing beyond a SystemVerilog compiler.
package dep_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_SIGN,
    ST_FETCH,
    ST_ARG,
    ST_DIGIT,
    ST_WRITE
  } dep_state_type;
endpackage

// [verilog/dep_cursor_if.sv]
// carrier between the engine and its source digit cursor.
// assumes both ends use the same address and length widths.
`timescale 1ns/100ps
interface dep_cursor_if #(parameter int AW = 32, parameter int LW = 5);
  logic          load;
  logic          advance;
  logic [AW-1:0] base;
  logic [LW-1:0] len;
  logic [AW-1:0] byte_addr;
  logic          hi_nib;
  logic          empty;
  modport engine (output load, advance, base, len,
                  input  byte_addr, hi_nib, empty);
  modport cursor (input  load, advance, base, len,
                  output byte_addr, hi_nib, empty);
endinterface

// [verilog/dep_digit_cursor.sv]
// source digit cursor: tracks which packed decimal digit comes next.
// assumes load and advance are one-cycle strobes qualified by ce.
`timescale 1ns/100ps
module dep_digit_cursor #(parameter int AW = 32, parameter int LW = 5)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  dep_cursor_if.cursor    cur
);
  logic [AW-1:0] base_ff;
  logic [LW-1:0] len_ff;
  logic [LW-1:0] idx_ff;
  logic [LW:0]   pos;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      base_ff <= '0;
      len_ff  <= '0;
    end
    else if (ce && cur.load)
    begin
      base_ff <= cur.base;
      len_ff  <= cur.len;
    end

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      idx_ff <= '0;
    else if (ce && cur.load)
      idx_ff <= '0;
    else if (ce && cur.advance && !cur.empty)
      idx_ff <= idx_ff + 1'b1;

  // even digit counts carry a pad nibble ahead of the first digit
  assign pos           = {1'b0, idx_ff} + {{LW{1'b0}}, ~len_ff[0]};
  assign cur.byte_addr = base_ff + AW'(pos[LW:1]);
  assign cur.hi_nib    = ~pos[0];
  assign cur.empty     = (idx_ff >= len_ff);
endmodule

// [verif/dep_engine_properties.sv]
// port assertions for the decimal edit pattern engine.
// assumes a bind onto dep_engine; one clock, reset rst.
`timescale 1ns/100ps
module dep_engine_checker #(parameter int AW = 32, parameter int LW = 5)
(
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          ce,
  input wire logic          start,
  input wire logic          mem_req,
  input wire logic          mem_we,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [7:0]    mem_wdata,
  input wire logic          mem_ack,
  input wire logic          busy,
  input wire logic          done,
  input wire logic          signif,
  input wire logic          zero_flag,
  input wire logic [15:0]   fill_sign_holder,
  input wire logic [AW-1:0] dst_next
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_req_hold;
    mem_req && !mem_ack && ce |=> mem_req && $stable(mem_addr)
      && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before its ack");

  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held longer than one cycle");

  property p_done_busy;
    done |-> !busy && $past(busy);
  endproperty
  a_done_busy: assert property (p_done_busy)
    else $error("done without busy ending");

  property p_start_busy;
    start && ce && !busy |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not raise busy");

  // float may clear zero a little before the digit lands
  property p_zero_signif;
    $fell(zero_flag) |-> ##[0:3] signif;
  endproperty
  a_zero_signif: assert property (p_zero_signif)
    else $error("zero flag cleared without significance");

  property p_holder_idle;
    !busy && !start |=> $stable(fill_sign_holder);
  endproperty
  a_holder_idle: assert property (p_holder_idle)
    else $error("fill and sign holder changed while idle");

  property p_no_req_idle;
    !busy |-> !mem_req;
  endproperty
  a_no_req_idle: assert property (p_no_req_idle)
    else $error("memory request while idle");

  property p_dst_step;
    mem_req && mem_we && mem_ack && ce && mem_addr == dst_next
      |=> dst_next == $past(dst_next) + 1;
  endproperty
  a_dst_step: assert property (p_dst_step)
    else $error("destination pointer did not step on write");
endmodule

bind dep_engine dep_engine_checker #(.AW(AW), .LW(LW)) dep_engine_checker_i
(
  .clk_sys, .rst, .ce, .start, .mem_req, .mem_we, .mem_addr, .mem_wdata,
  .mem_ack, .busy, .done, .signif, .zero_flag, .fill_sign_holder, .dst_next
);

// [verif/dep_mem_model.sv]
// byte memory behind the engine's memory port.
// assumes requests held until ack; slow sets wait cycles before each ack.
`timescale 1ns/100ps
module dep_mem_model
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:1023];
  logic [3:0] wait_cnt;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      mem_rdata <= 8'h5a;
    end
    else if (mem_ack)
    begin
      // released data must not look like the last byte
      mem_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_req && wait_cnt >= slow)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr[9:0]];
      if (mem_we)
        mem[mem_addr[9:0]] <= mem_wdata;
    end
    else if (mem_req)
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// [verif/testbench.sv]
// self-checking bench for the decimal edit pattern engine.
// assumes dep_mem_model holds source 0x100, pattern 0x200, dest 0x300.
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic [191:0] pat;
    int           pb;
    logic [15:0]  src;
    int           n;
    logic [127:0] exp;
    logic         bad;
    logic [15:0]  hold;
  } dep_row_type;

  logic        clk_sys, rst, start, mem_req, mem_we, mem_ack;
  logic        busy, done, bad_op, signif, zero_flag;
  logic [3:0]  slow;
  logic [31:0] mem_addr, dst_next;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [15:0] holder;
  int          failures, check_count;
  dep_row_type rows [0:6];

  dep_engine dep_engine_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .start(start), .src_len(5'd3), .src_addr(32'h100), .pat_addr(32'h200),
    .dst_addr(32'h300), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .bad_op(bad_op),
    .signif(signif), .zero_flag(zero_flag), .negative(),
    .fill_sign_holder(holder), .dst_next(dst_next));

  dep_mem_model dep_mem_model_i (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic launch(input dep_row_type r);
    for (int i = 0; i < 24; i++)
      dep_mem_model_i.mem[10'h200 + i] =
        i < r.pb ? r.pat[8*(r.pb-1-i) +: 8] : 8'h00;
    dep_mem_model_i.mem[10'h100] = r.src[15:8];
    dep_mem_model_i.mem[10'h101] = r.src[7:0];
    for (int i = 0; i < 16; i++)
      dep_mem_model_i.mem[10'h300 + i] = 8'hee;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
  endtask

  task automatic run_row(input dep_row_type r);
    int         k;
    logic [7:0] e;
    launch(r);
    k = 0;
    while (done !== 1'b1 && k < 600)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (done !== 1'b1)
    begin
      failures++;
      test_done();
    end
    for (int i = 0; i < 16; i++)
    begin
      e = i < r.n ? r.exp[8*(r.n-1-i) +: 8] : 8'hee;
      check("dst byte", dep_mem_model_i.mem[10'h300 + i], e);
    end
    check("holder", holder, r.hold);
    check("bad_op", bad_op, r.bad);
    check("dst_next", dst_next, 32'h300 + r.n);
    check("busy", busy, 1'b0);
    @(negedge clk_sys);
  endtask

  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    slow = 4'h0;
    failures = 0;
    check_count = 0;
    rows[0] = '{192'h93460100, 4, 16'h012c, 3, 128'h203132, 1'b0, 16'h2020};
    rows[1] = '{192'ha30100, 3, 16'h012d, 4, 128'h202d3132, 1'b0, 16'h2d20};
    // float run starts insignificant, patch length inside output
    rows[2] = '{192'ha301460100, 5, 16'h000d, 4, 128'h20202020, 1'b0,
                16'h2d20};
    rows[3] = '{192'h402a4124422b434582442c03442c04029100, 18, 16'h012d, 6,
                128'h2a2a2a2c452a, 1'b0, 16'h452a};
    rows[4] = '{192'h422b432d0400, 6, 16'h012c, 1, 128'h2b, 1'b0, 16'h2b20};
    rows[5] = '{192'h4500, 2, 16'h012c, 0, 128'h0, 1'b1, 16'h2020};
    rows[6] = '{192'h8f00, 2, 16'h012c, 15, {15{8'h20}}, 1'b0, 16'h2020};
    repeat (3) @(negedge clk_sys);
    check("reset busy", busy, 1'b0);
    check("reset req", mem_req, 1'b0);
    check("reset zero", zero_flag, 1'b1);
    check("reset holder", holder, 16'h2020);
    rst = 1'b0;
    @(negedge clk_sys);
    foreach (rows[i])
      run_row(rows[i]);
    // slow memory: request must hold through the wait
    slow = 4'h3;
    run_row(rows[3]);
    slow = 4'h0;
    // reset in mid edit, then a clean edit afterwards
    launch(rows[3]);
    repeat (6) @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    check("mid reset busy", busy, 1'b0);
    check("mid reset req", mem_req, 1'b0);
    check("mid reset signif", signif, 1'b0);
    check("mid reset holder", holder, 16'h2020);
    rst = 1'b0;
    @(negedge clk_sys);
    run_row(rows[0]);
    test_done();
  end
endmodule
